// ==== edc_map.svh ====
// Constants for the page-mode dynamic memory controller.
`ifndef EDC_MAP_SVH
`define EDC_MAP_SVH
`define EDC_CLK_PERIOD_NS 10
`define EDC_T_POWERUP_NS 200000
`define EDC_T_REFRESH_NS 4000000
`define EDC_REFRESH_ROWS 256
// Cycle counts derived from the times above; the power-up count rounds up, the refresh gap rounds down.
`define EDC_POWERUP_CYC ((`EDC_T_POWERUP_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_REFRESH_GAP_CYC (`EDC_T_REFRESH_NS / `EDC_REFRESH_ROWS / `EDC_CLK_PERIOD_NS)
`define EDC_WAKE_CYCLES 8
`define EDC_RAS_ACTIVE_CYC 5
`define EDC_PRECHARGE_CYC 3
`define EDC_CAS_CYC 2
`define EDC_ROW_BITS 8
`define EDC_FIFO_DEPTH 16
`endif

// ==== edc_pkg.sv ====
// Types shared by the page-mode dynamic memory controller.
`default_nettype none
package edc_pkg;
  typedef enum logic [1:0] {
    EDC_OP_READ,
    EDC_OP_WRITE,
    EDC_OP_RMW
  } edc_op_e;
  typedef enum {
    EDC_ST_POWERUP,
    EDC_ST_IDLE,
    EDC_ST_ROW,
    EDC_ST_COL,
    EDC_ST_RMW_WR,
    EDC_ST_COL_UP,
    EDC_ST_CBR_CAS,
    EDC_ST_CBR_RAS,
    EDC_ST_CLOSE,
    EDC_ST_PRECHARGE
  } edc_state_e;
  typedef logic [15:0] edc_word_t;
endpackage : edc_pkg
`default_nettype wire

// ==== edc_fifo.sv ====
// Parameterised valid/ready FIFO for the read data path.
`default_nettype none
module edc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : edc_fifo
`default_nettype wire

// ==== edc_ctrl.sv ====
// Controller that drives a page-mode asynchronous dynamic memory by pins.
`include "edc_map.svh"
`default_nettype none
module edc_ctrl #(
  parameter int POWERUP_CYC = `EDC_POWERUP_CYC,
  parameter int REFRESH_GAP_CYC = `EDC_REFRESH_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [15:0] req_addr,
  input wire logic [1:0] req_byte_en,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [15:0] rsp_data,
  output logic init_done,
  output logic row_strobe_n,
  output logic lower_column_strobe_n,
  output logic upper_column_strobe_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic [7:0] mux_address,
  input wire logic [15:0] data_lines_in,
  output logic [15:0] data_lines_out,
  output logic [15:0] data_lines_oe
);
  edc_pkg::edc_state_e state_r;
  logic [17:0] timer_r;
  logic [17:0] refresh_cnt_r;
  logic refresh_due_r;
  logic overrun_r;
  logic [3:0] wake_cnt_r;
  logic [7:0] open_row_r;
  logic row_open_r;
  logic [1:0] op_r;
  logic [7:0] col_r;
  logic [1:0] be_r;
  logic [15:0] wdata_r;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;

  // Page hit: same row while a row is still held open.
  function automatic logic page_hit(input logic [15:0] addr,
                                    input logic [7:0] row,
                                    input logic open);
    page_hit = open && (addr[15:8] == row);
  endfunction : page_hit

  // Read data is captured into the FIFO at the end of the column phase.
  assign fifo_in_valid = (state_r == edc_pkg::EDC_ST_COL) && (timer_r == '0)
                         && (op_r != 2'(edc_pkg::EDC_OP_WRITE));

  edc_fifo #(.WIDTH(16), .DEPTH(`EDC_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(data_lines_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // The head leaves the FIFO only when the output stage can take it.
  assign fifo_out_ready = !rsp_valid || rsp_ready;

  // Registered copies of the FIFO head keep the outputs flop-driven.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else if (fifo_out_ready) begin
      rsp_valid <= fifo_out_valid;
      rsp_data <= fifo_out_data;
    end
  end

  // Refresh interval timer; a missed slot marks an overrun.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refresh_cnt_r <= '0;
      refresh_due_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      // Clear comes first so a new slot in the same cycle wins.
      if (state_r == edc_pkg::EDC_ST_CBR_RAS && timer_r == '0) begin
        refresh_due_r <= 1'b0;
      end
      if (refresh_cnt_r >= 18'(REFRESH_GAP_CYC - 1)) begin
        refresh_cnt_r <= '0;
        refresh_due_r <= 1'b1;
        if (refresh_due_r && init_done) begin
          overrun_r <= 1'b1;
        end
      end else begin
        refresh_cnt_r <= refresh_cnt_r + 18'(1);
      end
      if (state_r == edc_pkg::EDC_ST_POWERUP) begin
        overrun_r <= 1'b0;
      end
    end
  end

  // Main sequencer.  Every request is a full row cycle unless it hits the
  // open row, in which case only a new column is strobed.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= edc_pkg::EDC_ST_POWERUP;
      timer_r <= 18'(POWERUP_CYC);
      wake_cnt_r <= 4'h0;
      init_done <= 1'b0;
      req_ready <= 1'b0;
      row_strobe_n <= 1'b1;
      lower_column_strobe_n <= 1'b1;
      upper_column_strobe_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      mux_address <= 8'h00;
      data_lines_out <= 16'h0000;
      data_lines_oe <= 16'h0000;
      open_row_r <= 8'h00;
      row_open_r <= 1'b0;
      op_r <= 2'h0;
      col_r <= 8'h00;
      be_r <= 2'h0;
      wdata_r <= 16'h0000;
    end else begin
      req_ready <= 1'b0;
      if (timer_r != '0) begin
        timer_r <= timer_r - 18'(1);
      end
      case (state_r)
        edc_pkg::EDC_ST_POWERUP: begin
          // Pause, then eight row-only wake-up cycles.
          if (timer_r == '0) begin
            if (wake_cnt_r == 4'(`EDC_WAKE_CYCLES)) begin
              init_done <= 1'b1;
              state_r <= edc_pkg::EDC_ST_IDLE;
            end else begin
              row_strobe_n <= 1'b0;
              mux_address <= 8'(wake_cnt_r);
              wake_cnt_r <= wake_cnt_r + 4'h1;
              timer_r <= 18'(`EDC_RAS_ACTIVE_CYC);
              state_r <= edc_pkg::EDC_ST_CLOSE;
            end
          end
        end
        edc_pkg::EDC_ST_IDLE: begin
          if (overrun_r) begin
            init_done <= 1'b0;
            wake_cnt_r <= 4'h0;
            row_open_r <= 1'b0;
            row_strobe_n <= 1'b1;
            timer_r <= 18'(`EDC_PRECHARGE_CYC);
            state_r <= edc_pkg::EDC_ST_POWERUP;
          end else if (refresh_due_r) begin
            if (row_open_r) begin
              row_strobe_n <= 1'b1;
              row_open_r <= 1'b0;
              timer_r <= 18'(`EDC_PRECHARGE_CYC);
              state_r <= edc_pkg::EDC_ST_PRECHARGE;
            end else begin
              // Column strobes fall first for a counter refresh.
              lower_column_strobe_n <= 1'b0;
              upper_column_strobe_n <= 1'b0;
              data_lines_oe <= 16'h0000;
              timer_r <= 18'(1);
              state_r <= edc_pkg::EDC_ST_CBR_CAS;
            end
          end else if (req_valid && fifo_in_ready && !req_ready) begin
            req_ready <= 1'b1;
            op_r <= req_op;
            col_r <= req_addr[7:0];
            be_r <= req_byte_en;
            wdata_r <= req_wdata;
            if (page_hit(req_addr, open_row_r, row_open_r)) begin
              timer_r <= '0;
              state_r <= edc_pkg::EDC_ST_ROW;
            end else if (row_open_r) begin
              // Miss: close the row; the request stays waiting untaken.
              req_ready <= 1'b0;
              row_strobe_n <= 1'b1;
              row_open_r <= 1'b0;
              timer_r <= 18'(`EDC_PRECHARGE_CYC);
              state_r <= edc_pkg::EDC_ST_PRECHARGE;
            end else begin
              mux_address <= req_addr[15:8];
              row_strobe_n <= 1'b0;
              open_row_r <= req_addr[15:8];
              row_open_r <= 1'b1;
              timer_r <= 18'(1);
              state_r <= edc_pkg::EDC_ST_ROW;
            end
          end
        end
        edc_pkg::EDC_ST_PRECHARGE: begin
          // A row miss is taken after precharge as a fresh row cycle.
          if (timer_r == '0) begin
            state_r <= edc_pkg::EDC_ST_IDLE;
          end
        end
        edc_pkg::EDC_ST_ROW: begin
          if (timer_r == '0) begin
            mux_address <= col_r;
            write_enable_n <= (op_r != 2'(edc_pkg::EDC_OP_WRITE));
            output_enable_n <= (op_r == 2'(edc_pkg::EDC_OP_WRITE));
            data_lines_out <= wdata_r;
            data_lines_oe <= (op_r == 2'(edc_pkg::EDC_OP_WRITE)) ?
                             {{8{be_r[1]}}, {8{be_r[0]}}} : 16'h0000;
            lower_column_strobe_n <= !be_r[0];
            upper_column_strobe_n <= !be_r[1];
            timer_r <= 18'(`EDC_CAS_CYC);
            state_r <= edc_pkg::EDC_ST_COL;
          end
        end
        edc_pkg::EDC_ST_COL: begin
          if (timer_r == '0) begin
            if (op_r == 2'(edc_pkg::EDC_OP_RMW)) begin
              // Output enable goes high before write enable falls.
              output_enable_n <= 1'b1;
              data_lines_out <= wdata_r;
              data_lines_oe <= {{8{be_r[1]}}, {8{be_r[0]}}};
              timer_r <= 18'(1);
              state_r <= edc_pkg::EDC_ST_RMW_WR;
            end else begin
              lower_column_strobe_n <= 1'b1;
              upper_column_strobe_n <= 1'b1;
              timer_r <= 18'(1);
              state_r <= edc_pkg::EDC_ST_COL_UP;
            end
          end
        end
        edc_pkg::EDC_ST_RMW_WR: begin
          write_enable_n <= 1'b0;
          if (timer_r == '0) begin
            lower_column_strobe_n <= 1'b1;
            upper_column_strobe_n <= 1'b1;
            timer_r <= 18'(1);
            state_r <= edc_pkg::EDC_ST_COL_UP;
          end
        end
        edc_pkg::EDC_ST_COL_UP: begin
          // Row stays open so the next access can be a page hit.
          if (timer_r == '0) begin
            write_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            data_lines_oe <= 16'h0000;
            op_r <= 2'h3;
            state_r <= edc_pkg::EDC_ST_IDLE;
          end
        end
        edc_pkg::EDC_ST_CBR_CAS: begin
          if (timer_r == '0) begin
            row_strobe_n <= 1'b0;
            timer_r <= 18'(`EDC_RAS_ACTIVE_CYC);
            state_r <= edc_pkg::EDC_ST_CBR_RAS;
          end
        end
        edc_pkg::EDC_ST_CBR_RAS: begin
          if (timer_r == '0) begin
            lower_column_strobe_n <= 1'b1;
            upper_column_strobe_n <= 1'b1;
            row_strobe_n <= 1'b1;
            timer_r <= 18'(`EDC_PRECHARGE_CYC);
            state_r <= edc_pkg::EDC_ST_PRECHARGE;
          end
        end
        edc_pkg::EDC_ST_CLOSE: begin
          // Row active time is held before the strobe rises.
          if (timer_r == '0) begin
            row_strobe_n <= 1'b1;
            timer_r <= 18'(`EDC_PRECHARGE_CYC);
            state_r <= edc_pkg::EDC_ST_POWERUP;
          end
        end
        default: begin
          state_r <= edc_pkg::EDC_ST_IDLE;
        end
      endcase
    end
  end

  // Write data must already be on the pins when write enable falls.
  a_write_data_setup: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(write_enable_n) |-> data_lines_oe != 16'h0000)
    else $error("write enable fell with data undriven");

  // Column-first refresh: a byte strobe is low when the row strobe falls.
  a_cbr_strobe_order: assert property (@(posedge sys_clk) disable iff (reset)
    ($fell(row_strobe_n) && state_r == edc_pkg::EDC_ST_CBR_RAS) |->
    (!lower_column_strobe_n || !upper_column_strobe_n))
    else $error("row strobe fell without a column strobe low");

  // No data driven during a counter refresh.
  a_cbr_data_off: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == edc_pkg::EDC_ST_CBR_RAS |-> data_lines_oe == 16'h0000)
    else $error("data driven in counter refresh");

  // Row strobe stays low for the active minimum once it falls.
  sequence s_row_open;
    $fell(row_strobe_n);
  endsequence
  a_row_active_min: assert property (@(posedge sys_clk) disable iff (reset)
    s_row_open |=> !row_strobe_n [*2])
    else $error("row strobe released too early");

  // Modify-write never has both enables low together.
  a_rmw_enable_gap: assert property (@(posedge sys_clk) disable iff (reset)
    !(write_enable_n == 1'b0 && output_enable_n == 1'b0))
    else $error("write and output enables both low");

  // A read keeps write enable high while the column strobes are low.
  a_read_we_high: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == edc_pkg::EDC_ST_COL && op_r == 2'(edc_pkg::EDC_OP_READ))
    |-> write_enable_n)
    else $error("write enable low during read");

  // No request is accepted before wake-up is complete.
  a_init_first: assert property (@(posedge sys_clk) disable iff (reset)
    req_ready |-> $past(init_done))
    else $error("request accepted before initialisation");

  // A due refresh is served within the interval slot.
  a_refresh_served: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(refresh_due_r) && init_done |-> ##[1:60] !refresh_due_r)
    else $error("refresh not served in time");
endmodule : edc_ctrl
`default_nettype wire

// ==== edc_dram_model.sv ====
// Behavioural model of the page-mode dynamic memory behind the controller.
`default_nettype none
module edc_dram_model #(
  parameter int T_RAS_MIN_NS = 30,
  parameter int T_RP_MIN_NS = 20
) (
  input wire logic row_strobe_n,
  input wire logic lower_column_strobe_n,
  input wire logic upper_column_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [7:0] mux_address,
  input wire logic [15:0] data_lines_out,
  input wire logic [15:0] data_lines_oe,
  output logic [15:0] data_lines_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:65535];
  logic [7:0] row_q;
  logic [7:0] col_q;
  logic [15:0] rd_q;
  logic [15:0] mask;
  logic [1:0] on_q;
  logic [1:0] strb;
  logic cbr_q;
  logic cas_was_high;
  logic live;
  time t_fall;
  time t_rise;
  int ras_falls;
  int cbr_cnt;
  int viol_cnt;
  wire logic cas_n;
  // One internal strobe: low while either byte strobe is low.
  assign cas_n = lower_column_strobe_n & upper_column_strobe_n;
  // Released byte lanes show the inverse of the last value, never a copy.
  assign data_lines_in = {on_q[1] ? rd_q[15:8] : ~rd_q[15:8],
                          on_q[0] ? rd_q[7:0] : ~rd_q[7:0]};
  // Contents start as the inverted address so reads of fresh words are known.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = ~i[15:0];
    end
    rd_q = 16'h0000;
    on_q = 2'b00;
    cbr_q = 1'b0;
    cas_was_high = 1'b1;
    live = 1'b0;
    t_fall = 0;
    t_rise = 0;
    ras_falls = 0;
    cbr_cnt = 0;
    viol_cnt = 0;
  end
  // Row strobe falling opens a cycle, or a refresh when a column is low.
  always @(negedge row_strobe_n) begin
    if (live && ($time - t_rise) < T_RP_MIN_NS) begin
      viol_cnt++;
    end
    live = 1'b1;
    t_fall = $time;
    ras_falls++;
    cbr_q = (cas_n === 1'b0);
    if (cbr_q) begin
      cbr_cnt++;
    end else begin
      row_q = mux_address;
    end
  end
  // A cycle ends when row and columns are high; the read lanes are then released.
  always @(posedge row_strobe_n) begin
    if (live && ($time - t_fall) < T_RAS_MIN_NS) begin
      viol_cnt++;
    end
    t_rise = $time;
    if (cas_n !== 1'b0) begin
      on_q = 2'b00;
    end
  end
  // Data stays driven past the column rise while the row is open.
  always @(posedge cas_n) begin
    cas_was_high = 1'b1;
    if (row_strobe_n !== 1'b0) begin
      on_q = 2'b00;
    end
  end
  // Output enable high turns the read lanes off.
  always @(posedge output_enable_n) begin
    on_q = 2'b00;
  end
  // Column latch at the first column strobe fall; reads and writes start at the later falling edge.
  always @(negedge lower_column_strobe_n or negedge upper_column_strobe_n
           or negedge write_enable_n or negedge output_enable_n) begin
    if (row_strobe_n === 1'b0 && !cbr_q) begin
      if (cas_n === 1'b0 && cas_was_high) begin
        col_q = mux_address;
        on_q = 2'b00;
        cas_was_high = 1'b0;
      end
      strb = ~{upper_column_strobe_n, lower_column_strobe_n};
      mask = {{8{strb[1]}}, {8{strb[0]}}};
      if (write_enable_n === 1'b0) begin
        if ((data_lines_oe & mask) !== mask || output_enable_n === 1'b0) begin
          viol_cnt++;
        end
        on_q = 2'b00;
        for (int b = 0; b < 2; b++) begin
          if (strb[b]) begin
            mem[{row_q, col_q}][b*8 +: 8] = data_lines_out[b*8 +: 8];
          end
        end
      end else if (output_enable_n === 1'b0) begin
        rd_q = mem[{row_q, col_q}];
        on_q = strb;
      end
    end
  end
endmodule : edc_dram_model
`default_nettype wire

// ==== test_edc_ctrl.sv ====
// Self-checking bench for the page-mode dynamic memory controller.
`default_nettype none
module test_edc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PWR = 20;
  localparam int GAP = 60;
  logic sys_clk, reset, req_valid, req_ready, rsp_valid, rsp_ready, init_done;
  logic [1:0] req_op, req_byte_en;
  logic [15:0] req_addr, req_wdata, rsp_data;
  logic row_strobe_n, lower_column_strobe_n, upper_column_strobe_n;
  logic write_enable_n, output_enable_n;
  logic [7:0] mux_address;
  logic [15:0] data_lines_in, data_lines_out, data_lines_oe;
  logic [15:0] got;
  int error_cnt, n_tests, cyc, c0, f0;
  bit ok;
  edc_ctrl #(.POWERUP_CYC(PWR), .REFRESH_GAP_CYC(GAP)) u_edc_ctrl (
    .sys_clk, .reset, .req_valid, .req_ready, .req_op, .req_addr,
    .req_byte_en, .req_wdata, .rsp_valid, .rsp_ready, .rsp_data, .init_done,
    .row_strobe_n, .lower_column_strobe_n, .upper_column_strobe_n,
    .write_enable_n, .output_enable_n, .mux_address, .data_lines_in,
    .data_lines_out, .data_lines_oe);
  edc_dram_model u_edc_dram_model (
    .row_strobe_n, .lower_column_strobe_n, .upper_column_strobe_n,
    .write_enable_n, .output_enable_n, .mux_address, .data_lines_out,
    .data_lines_oe, .data_lines_in);
  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk16(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk16
  // Passes when seen is at least lo.
  task chk_min(input string what, input int lo, input int seen);
    n_tests++;
    if (seen < lo) begin
      error_cnt++;
      $display("[ERR] %s expected >= %0d seen %0d", what, lo, seen);
    end
  endtask : chk_min
  task end_sim;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Holds the request until it is taken; a refusal past lim cycles is noted.
  task send(input logic [1:0] op, input logic [15:0] a, input logic [1:0] be,
            input logic [15:0] wd, input int lim, output bit taken);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_byte_en <= be;
    req_wdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < lim);
    req_valid <= 1'b0;
    taken = (req_ready === 1'b1);
  endtask : send
  task recv(output logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    rsp_ready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    d = (rsp_valid === 1'b1) ? rsp_data : 16'hXXXX;
    rsp_ready <= 1'b0;
  endtask : recv
  task wr(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
    send(2'h1, a, be, d, 4000, ok);
    chk16("write taken", 16'h0001, {15'h0000, ok});
    repeat (4) @(posedge sys_clk);
  endtask : wr
  task rd(input logic [15:0] a, input logic [1:0] be, input logic [15:0] exp);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    send(2'h0, a, be, 16'h0000, 4000, ok);
    recv(got);
    chk16("read data", exp & m, got & m);
  endtask : rd
  task t_word;
    wr(16'h1234, 2'b11, 16'hBEEF);
    chk16("stored word", 16'hBEEF, u_edc_dram_model.mem[16'h1234]);
    rd(16'hAB00, 2'b11, 16'h54FF);
    rd(16'h1234, 2'b11, 16'hBEEF);
  endtask : t_word
  task t_byte;
    wr(16'h2001, 2'b11, 16'h1122);
    wr(16'h2001, 2'b01, 16'hFF33);
    chk16("low byte write", 16'h1133, u_edc_dram_model.mem[16'h2001]);
    wr(16'h2001, 2'b10, 16'h44FF);
    chk16("high byte write", 16'h4433, u_edc_dram_model.mem[16'h2001]);
    rd(16'h2001, 2'b01, 16'h4433);
    rd(16'h2001, 2'b10, 16'h4433);
  endtask : t_byte
  task t_page;
    f0 = u_edc_dram_model.ras_falls;
    c0 = u_edc_dram_model.cbr_cnt;
    wr(16'h3005, 2'b11, 16'h0505);
    wr(16'h30FA, 2'b11, 16'hFAFA);
    rd(16'h3005, 2'b11, 16'h0505);
    wr(16'h3006, 2'b11, 16'h0606);
    rd(16'h30FA, 2'b11, 16'hFAFA);
    rd(16'h3006, 2'b11, 16'h0606);
    chk_min("row opens in page", u_edc_dram_model.ras_falls - f0
            - (u_edc_dram_model.cbr_cnt - c0), 1 + 2 * (u_edc_dram_model.cbr_cnt - c0));
  endtask : t_page
  task t_rmw;
    wr(16'h4040, 2'b11, 16'h0F0F);
    send(2'h2, 16'h4040, 2'b11, 16'hF0F0, 4000, ok);
    recv(got);
    chk16("modify old data", 16'h0F0F, got);
    chk16("modify new data", 16'hF0F0, u_edc_dram_model.mem[16'h4040]);
  endtask : t_rmw
  task t_refresh;
    c0 = u_edc_dram_model.cbr_cnt;
    repeat (10 * GAP) @(posedge sys_clk);
    chk_min("refresh count", 9, u_edc_dram_model.cbr_cnt - c0);
    rd(16'h1234, 2'b11, 16'hBEEF);
  endtask : t_refresh
  // Reads pile up in the buffer while the consumer stalls, then drain in order.
  task t_fifo;
    int acc;
    acc = 0;
    for (int i = 0; i < 20; i++) begin
      send(2'h0, 16'h5000 + 16'(i), 2'b11, 16'h0000, 100, ok);
      if (!ok) break;
      acc++;
    end
    chk_min("buffered reads", 16, acc);
    chk_min("full buffer refuses", acc, 19);
    for (int i = 0; i < acc; i++) begin
      recv(got);
      chk16("drained word", ~(16'h5000 + 16'(i)), got);
    end
  endtask : t_fifo
  // Main sequence: reset, wake-up, then the scenarios.
  initial begin
    error_cnt = 0;
    n_tests = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 16'h0000;
    req_byte_en = 2'b11;
    req_wdata = 16'h0000;
    rsp_ready = 1'b0;
    repeat (12) @(posedge sys_clk);
    chk16("idle strobes", 16'h0007, {13'h0000, row_strobe_n,
          lower_column_strobe_n, upper_column_strobe_n});
    chk16("bus released", 16'h0000, data_lines_oe);
    reset <= 1'b0;
    cyc = 0;
    while (init_done !== 1'b1 && cyc < 3000) begin
      @(posedge sys_clk);
      cyc++;
    end
    chk_min("wake-up delay", PWR, cyc);
    chk_min("wake-up row cycles", 8, u_edc_dram_model.ras_falls);
    t_word();
    t_byte();
    t_page();
    t_rmw();
    t_refresh();
    t_fifo();
    chk_min("pin timing", u_edc_dram_model.viol_cnt, 0);
    chk16("init kept", 16'h0001, {15'h0000, init_done});
    end_sim();
  end
  // Watchdog sized well above the expected run of under two thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] run length expected done seen timeout");
    end_sim();
  end
endmodule : test_edc_ctrl
`default_nettype wire
